// [rtl/irt_pkg.sv]
/*
 * constants shared by the ingress rate table access block:
 * register indices, field positions, reset values, table layout.
 * assumes a 32-bit register bus with one word per register index.
 */
package irt_pkg;

    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_CFG      = 14'h184A;
    localparam logic [13:0] IDX_CMD      = 14'h184B;
    localparam logic [13:0] IDX_STS      = 14'h184C;
    localparam logic [13:0] IDX_WR_HOLD  = 14'h184D;
    localparam logic [13:0] IDX_RD_HOLD  = 14'h184E;
    localparam int          ADDR_W       = 16;

    // command register fields
    localparam int CMD_DIR_BIT  = 7;
    localparam int CMD_SEL_HI   = 6;
    localparam int CMD_SEL_LO   = 5;
    localparam int CMD_IDX_HI   = 4;
    localparam int CMD_IDX_LO   = 0;

    // config register fields
    localparam int CFG_EN_BIT   = 0;
    localparam int CFG_MODE_HI  = 2;
    localparam int CFG_MODE_LO  = 1;

    // status register fields
    localparam int STS_PEND_BIT = 0;

    // table layout: committed-rate entries, then the two burst entries
    localparam int          RATE_COUNT = 24;
    localparam int          TBL_DEPTH  = 26;
    localparam int          ENTRY_W    = 16;
    localparam logic [4:0]  SLOT_CBS   = 5'h18;
    localparam logic [4:0]  SLOT_EBS   = 5'h19;
    localparam logic [4:0]  RATE_LIMIT = 5'h18;

    // reset values
    localparam logic [15:0] RST_RATE   = 16'h0014;
    localparam logic [15:0] RST_BURST  = 16'h0600;
    localparam logic [7:0]  RST_CMD    = 8'h00;
    localparam logic [1:0]  RST_MODE   = 2'h0;

    // rate step: time per byte is (entry + 1) times this
    localparam logic [20:0] RATE_STEP_NS = 21'h14;

    // table select encodings
    typedef enum logic [1:0] {
        IRT_SEL_RSVD  = 2'b00,
        IRT_SEL_RATE  = 2'b01,
        IRT_SEL_CBS   = 2'b10,
        IRT_SEL_EBS   = 2'b11
    } irt_sel_t;

    // metering mode encodings
    typedef enum logic [1:0] {
        IRT_MODE_PORT_PRIO = 2'b00,
        IRT_MODE_PORT      = 2'b01,
        IRT_MODE_PRIO      = 2'b10,
        IRT_MODE_RSVD      = 2'b11
    } irt_mode_t;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// [rtl/irt_mem_if.sv]
/*
 * carrier between the access controller and the table memory:
 * one software port (read or write) and one metering read port.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface irt_mem_if;
    logic [4:0]  sw_addr;
    logic        sw_wen;
    logic        sw_ren;
    logic [15:0] sw_wdata;
    logic [15:0] sw_rdata;
    logic [4:0]  mt_addr;
    logic [15:0] mt_rdata;

    modport mem (input sw_addr, sw_wen, sw_ren, sw_wdata, mt_addr,
                 output sw_rdata, mt_rdata);
    modport ctl (output sw_addr, sw_wen, sw_ren, sw_wdata, mt_addr,
                 input sw_rdata, mt_rdata);
endinterface

// [rtl/irt_table_mem.sv]
/*
 * ingress rate table storage: committed-rate entries plus the
 * committed-burst and excess-burst entries, each 16 bits.
 * assumes slot addresses below the depth; others read as zero.
 * read data of both ports come out of registers.
 */
`timescale 1ns/1ns
module irt_table_mem (
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   resetn,
    // table ports
    irt_mem_if.mem      bus
);

    logic [15:0] entry_ff [irt_pkg::TBL_DEPTH];
    logic [15:0] sw_rdata_ff;
    logic [15:0] mt_rdata_ff;

    // one storage word per slot, each with its own reset value
    genvar g;
    generate
        for (g = 0; g < irt_pkg::TBL_DEPTH; g++) begin : g_entry
            localparam logic [15:0] RST_VAL = (g < irt_pkg::RATE_COUNT) ?
                irt_pkg::RST_RATE : irt_pkg::RST_BURST;
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    entry_ff[g] <= RST_VAL;
                end else if (bus.sw_wen && bus.sw_addr == 5'(g)) begin
                    entry_ff[g] <= bus.sw_wdata;
                end
            end
        end
    endgenerate

    // software read port, registered
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sw_rdata_ff <= 16'h0000;
        end else if (bus.sw_ren) begin
            sw_rdata_ff <= (bus.sw_addr < 5'(irt_pkg::TBL_DEPTH)) ?
                entry_ff[bus.sw_addr] : 16'h0000;
        end
    end

    // metering read port, registered every cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mt_rdata_ff <= 16'h0000;
        end else begin
            mt_rdata_ff <= (bus.mt_addr < 5'(irt_pkg::TBL_DEPTH)) ?
                entry_ff[bus.mt_addr] : 16'h0000;
        end
    end

    assign bus.sw_rdata = sw_rdata_ff;
    assign bus.mt_rdata = mt_rdata_ff;

endmodule

// [rtl/irt_top.sv]
/*
 * ingress rate table indirect access: AXI4-Lite register bank with
 * config, command, status and two holding registers, a command engine
 * moving words between the holding registers and the rate table, and
 * a metering lookup port that maps port/priority to a committed rate.
 * assumes the metering inputs are on sys_clk; software obeys the
 * pending flag before issuing another command.
 */
// Decided for this implementation: the AXI4-Lite slave port.
// Overview of operation
// - a software write of the command register while pending is clear starts one table access from its fields.
// - on a read, pending stays set until the fetched word lands, then software reads it.
// - on a write, software loads the write holding register first; pending shows completion.
// - command bit 7 high means table read, low means table write.
// - select bits 6:5 choose 01 rate entries by index, 10 committed burst, 11 excess burst.
// - index bits 4:0 choose one of 24 committed-rate entries.
// - port-and-priority mode: port 0 at 0-7, port 1 at 8-15, port 2 at 16-23, priority 0 lowest.
// - port-only mode maps rate entries 0, 1 and 2 to ports 0, 1 and 2.
// - priority-only mode maps each entry index to the same priority, 0 to 23.
// - the table holds 24 rate entries plus one committed-burst and one excess-burst entry.
// - every entry is 16 bits and is reached only through the command mechanism.
// - pending is set while a command runs and cleared by hardware when it ends.
// - metering mode 00 is port and priority, 01 port only, 10 priority only, 11 reserved.
// - a rate entry gives time per byte as the stored value plus one times 20 ns.
`timescale 1ns/1ns
module irt_top (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // axi4-lite write address
    input  wire logic [15:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read address
    input  wire logic [15:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    // axi4-lite read data
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // metering lookup
    input  wire logic [1:0]           meter_port,
    input  wire logic [4:0]           meter_prio,
    output logic [15:0]               meter_rate,
    output logic [20:0]               meter_ns_per_byte,
    output logic                      meter_enable,
    output logic [1:0]                meter_mode
);

    irt_mem_if mif ();

    // bus state
    logic                s_axi_awready_ff;
    logic                s_axi_wready_ff;
    logic                s_axi_bvalid_ff;
    logic [1:0]          s_axi_bresp_ff;
    logic                s_axi_arready_ff;
    logic                s_axi_rvalid_ff;
    logic [31:0]         s_axi_rdata_ff;
    logic [1:0]          s_axi_rresp_ff;
    logic [13:0]         aw_idx_ff;
    logic                aw_full_ff;
    logic [31:0]         w_data_ff;
    logic [3:0]          w_strb_ff;
    logic                w_full_ff;

    // register bank
    logic                rate_en_ff;
    logic [1:0]          rate_mode_ff;
    logic [7:0]          rate_table_command_ff;
    logic                pending_ff;
    logic [15:0]         rate_table_write_holding_ff;
    logic [15:0]         rate_table_read_holding_ff;

    // command engine
    typedef enum logic [1:0] {
        IRT_ST_IDLE  = 2'b00,
        IRT_ST_ISSUE = 2'b01,
        IRT_ST_FETCH = 2'b10
    } irt_state_t;
    irt_state_t          state_ff;
    irt_state_t          nxt_state;

    // metering outputs
    logic [15:0]         meter_rate_ff;
    logic [20:0]         meter_ns_ff;

    // decode
    logic                wr_fire;
    logic                rd_fire;
    logic                wr_hit;
    logic                rd_hit;
    logic [13:0]         ar_idx;
    logic                cmd_launch;
    logic                cmd_is_read;
    logic [1:0]          cmd_sel;
    logic [4:0]          cmd_idx;
    logic [4:0]          slot;
    logic                slot_ok;
    logic [31:0]         rd_word;

    assign wr_fire = aw_full_ff && w_full_ff && !s_axi_bvalid_ff;
    assign rd_fire = s_axi_arvalid && s_axi_arready_ff;
    assign ar_idx  = s_axi_araddr[15:2];

    // write decode; tables have no address of their own
    always_comb begin
        case (aw_idx_ff)
            irt_pkg::IDX_CFG,
            irt_pkg::IDX_CMD,
            irt_pkg::IDX_STS,
            irt_pkg::IDX_WR_HOLD,
            irt_pkg::IDX_RD_HOLD: wr_hit = 1'b1;
            default:              wr_hit = 1'b0;
        endcase
    end

    // read mux; reserved bits read as zero
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (ar_idx)
            irt_pkg::IDX_CFG: begin
                rd_word[irt_pkg::CFG_EN_BIT] = rate_en_ff;
                rd_word[irt_pkg::CFG_MODE_HI:irt_pkg::CFG_MODE_LO] = rate_mode_ff;
            end
            irt_pkg::IDX_CMD:     rd_word[7:0]  = rate_table_command_ff;
            irt_pkg::IDX_STS:     rd_word[irt_pkg::STS_PEND_BIT] = pending_ff;
            irt_pkg::IDX_WR_HOLD: rd_word[15:0] = rate_table_write_holding_ff;
            irt_pkg::IDX_RD_HOLD: rd_word[15:0] = rate_table_read_holding_ff;
            default:              rd_hit = 1'b0;
        endcase
    end

    // write address channel; held until the response is taken
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready_ff <= 1'b1;
            aw_full_ff       <= 1'b0;
            aw_idx_ff        <= 14'h0000;
        end else if (s_axi_awvalid && s_axi_awready_ff) begin
            s_axi_awready_ff <= 1'b0;
            aw_full_ff       <= 1'b1;
            aw_idx_ff        <= s_axi_awaddr[15:2];
        end else if (s_axi_bvalid_ff && s_axi_bready) begin
            s_axi_awready_ff <= 1'b1;
            aw_full_ff       <= 1'b0;
        end
    end

    // write data channel, independent of the address
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_wready_ff <= 1'b1;
            w_full_ff       <= 1'b0;
            w_data_ff       <= 32'h0000_0000;
            w_strb_ff       <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready_ff) begin
            s_axi_wready_ff <= 1'b0;
            w_full_ff       <= 1'b1;
            w_data_ff       <= s_axi_wdata;
            w_strb_ff       <= s_axi_wstrb;
        end else if (s_axi_bvalid_ff && s_axi_bready) begin
            s_axi_wready_ff <= 1'b1;
            w_full_ff       <= 1'b0;
        end
    end

    // write response once both halves are in
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid_ff <= 1'b0;
            s_axi_bresp_ff  <= irt_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_ff <= 1'b1;
            s_axi_bresp_ff  <= wr_hit ? irt_pkg::RESP_OKAY : irt_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid_ff <= 1'b0;
        end
    end

    // read channel; data registered one cycle after the address
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready_ff <= 1'b1;
            s_axi_rvalid_ff  <= 1'b0;
            s_axi_rdata_ff   <= 32'h0000_0000;
            s_axi_rresp_ff   <= irt_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready_ff <= 1'b0;
            s_axi_rvalid_ff  <= 1'b1;
            s_axi_rdata_ff   <= rd_word;
            s_axi_rresp_ff   <= rd_hit ? irt_pkg::RESP_OKAY : irt_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid_ff && s_axi_rready) begin
            s_axi_arready_ff <= 1'b1;
            s_axi_rvalid_ff  <= 1'b0;
        end
    end

    // config register: enable and metering mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rate_en_ff   <= 1'b0;
            rate_mode_ff <= irt_pkg::RST_MODE;
        end else if (wr_fire && aw_idx_ff == irt_pkg::IDX_CFG && w_strb_ff[0]) begin
            rate_en_ff   <= w_data_ff[irt_pkg::CFG_EN_BIT];
            rate_mode_ff <= w_data_ff[irt_pkg::CFG_MODE_HI:irt_pkg::CFG_MODE_LO];
        end
    end

    // write holding register, loaded ahead of a table write
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rate_table_write_holding_ff <= 16'h0000;
        end else if (wr_fire && aw_idx_ff == irt_pkg::IDX_WR_HOLD) begin
            if (w_strb_ff[0]) begin
                rate_table_write_holding_ff[7:0] <= w_data_ff[7:0];
            end
            if (w_strb_ff[1]) begin
                rate_table_write_holding_ff[15:8] <= w_data_ff[15:8];
            end
        end
    end

    // a command write launches only when idle; busy writes are dropped
    assign cmd_launch = wr_fire && aw_idx_ff == irt_pkg::IDX_CMD && w_strb_ff[0]
                        && !pending_ff;

    // command register keeps the fields of the last launch
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rate_table_command_ff <= irt_pkg::RST_CMD;
        end else if (cmd_launch) begin
            rate_table_command_ff <= w_data_ff[7:0];
        end
    end

    // field split of the live command
    assign cmd_is_read = rate_table_command_ff[irt_pkg::CMD_DIR_BIT];
    assign cmd_sel     = rate_table_command_ff[irt_pkg::CMD_SEL_HI:irt_pkg::CMD_SEL_LO];
    assign cmd_idx     = rate_table_command_ff[irt_pkg::CMD_IDX_HI:irt_pkg::CMD_IDX_LO];

    // table slot from select and index; reserved select touches nothing
    always_comb begin
        slot    = 5'h00;
        slot_ok = 1'b0;
        case (cmd_sel)
            irt_pkg::IRT_SEL_RATE: begin
                slot    = cmd_idx;
                slot_ok = cmd_idx < irt_pkg::RATE_LIMIT;
            end
            irt_pkg::IRT_SEL_CBS: begin
                slot    = irt_pkg::SLOT_CBS;
                slot_ok = 1'b1;
            end
            irt_pkg::IRT_SEL_EBS: begin
                slot    = irt_pkg::SLOT_EBS;
                slot_ok = 1'b1;
            end
            default: begin
                slot    = 5'h00;
                slot_ok = 1'b0;
            end
        endcase
    end

    // engine next state: write in one cycle, read needs the fetch cycle
    always_comb begin
        case (state_ff)
            IRT_ST_IDLE:  nxt_state = cmd_launch ? IRT_ST_ISSUE : IRT_ST_IDLE;
            IRT_ST_ISSUE: nxt_state = cmd_is_read ? IRT_ST_FETCH : IRT_ST_IDLE;
            IRT_ST_FETCH: nxt_state = IRT_ST_IDLE;
            default:      nxt_state = IRT_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= IRT_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // pending: set on launch, cleared by hardware when done
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pending_ff <= 1'b0;
        end else if (cmd_launch) begin
            pending_ff <= 1'b1;
        end else if (state_ff != IRT_ST_IDLE && nxt_state == IRT_ST_IDLE) begin
            pending_ff <= 1'b0;
        end
    end

    // table port driven only in the issue cycle
    assign mif.sw_addr  = slot;
    assign mif.sw_wen   = state_ff == IRT_ST_ISSUE && !cmd_is_read && slot_ok;
    assign mif.sw_ren   = state_ff == IRT_ST_ISSUE && cmd_is_read && slot_ok;
    assign mif.sw_wdata = rate_table_write_holding_ff;

    // read holding register catches the fetched word; invalid slot gives zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rate_table_read_holding_ff <= 16'h0000;
        end else if (state_ff == IRT_ST_ISSUE && cmd_is_read && !slot_ok) begin
            rate_table_read_holding_ff <= 16'h0000;
        end else if (state_ff == IRT_ST_FETCH && slot_ok) begin
            rate_table_read_holding_ff <= mif.sw_rdata;
        end
    end

    // metering lookup index per mode; reserved mode acts as port+priority
    always_comb begin
        case (rate_mode_ff)
            irt_pkg::IRT_MODE_PORT:
                mif.mt_addr = {3'b000, meter_port};
            irt_pkg::IRT_MODE_PRIO:
                mif.mt_addr = meter_prio;
            default:
                mif.mt_addr = {meter_port, meter_prio[2:0]};
        endcase
    end

    // rate word and its time per byte, one cycle behind the table read
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meter_rate_ff <= irt_pkg::RST_RATE;
            meter_ns_ff   <= 21'h0;
        end else begin
            meter_rate_ff <= mif.mt_rdata;
            meter_ns_ff   <= 21'(({5'h00, mif.mt_rdata} + 21'h1) * irt_pkg::RATE_STEP_NS);
        end
    end

    irt_table_mem u_mem (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .bus     (mif.mem)
    );

    // outputs straight from flops
    assign s_axi_awready     = s_axi_awready_ff;
    assign s_axi_wready      = s_axi_wready_ff;
    assign s_axi_bvalid      = s_axi_bvalid_ff;
    assign s_axi_bresp       = s_axi_bresp_ff;
    assign s_axi_arready     = s_axi_arready_ff;
    assign s_axi_rvalid      = s_axi_rvalid_ff;
    assign s_axi_rdata       = s_axi_rdata_ff;
    assign s_axi_rresp       = s_axi_rresp_ff;
    assign meter_rate        = meter_rate_ff;
    assign meter_ns_per_byte = meter_ns_ff;
    assign meter_enable      = rate_en_ff;
    assign meter_mode        = rate_mode_ff;

endmodule

// [bench/irt_props.sv]
/* assertions on the rate table block's ports.
   assumes one clock, sys_clk, and async active-low resetn. */
`timescale 1ns/1ns
module irt_props (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // register bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // metering lookup
    input wire logic [15:0] meter_rate,
    input wire logic [20:0] meter_ns_per_byte,
    input wire logic        meter_enable,
    input wire logic [1:0]  meter_mode
);
    logic [1:0] settle_ff;
    // lookup outputs lag reset by two edges, so wait three
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            settle_ff <= 2'h0;
        end else if (settle_ff != 2'h3) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // handshake steps
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid && !s_axi_awready)
        else $error("no write answer after address and data");
    a_b_has_cause: assert property ($rose(s_axi_bvalid) |->
        $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready, 2))
        else $error("write answer without a taken write");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read answer after address");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer held after acceptance");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer held after acceptance");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_ns_scale: assert property (settle_ff == 2'h3 |->
        meter_ns_per_byte == ({5'h00, meter_rate} + 21'h1) * 21'h14)
        else $error("time per byte not scaled from rate");
    a_cfg_source: assert property (!$stable({meter_enable, meter_mode}) |->
        s_axi_bvalid || $past(s_axi_bvalid))
        else $error("metering mode changed without a write");
endmodule
bind irt_top irt_props i_irt_props (.*);

// [bench/tb.sv]
/* self-checking bench for the rate table block over axi4-lite.
   assumes bready and rready stay high; the master waits on answers. */
`timescale 1ns/1ns
module tb;
    logic        sys_clk, resetn, meter_enable;
    logic [15:0] s_axi_awaddr, s_axi_araddr, meter_rate;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, meter_port, meter_mode, r;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [4:0]  meter_prio;
    logic [20:0] meter_ns_per_byte, e;
    int          error_cnt, tests_run, i;
    localparam logic [15:0] A_CFG = {irt_pkg::IDX_CFG, 2'b00};
    localparam logic [15:0] A_CMD = {irt_pkg::IDX_CMD, 2'b00};
    localparam logic [15:0] A_STS = {irt_pkg::IDX_STS, 2'b00};
    localparam logic [15:0] A_WR  = {irt_pkg::IDX_WR_HOLD, 2'b00};
    localparam logic [15:0] A_RD  = {irt_pkg::IDX_RD_HOLD, 2'b00};
    localparam logic [15:0] A_BAD = 16'h6140;
    // lookup cases: mode, port, priority, expected entry
    localparam logic [1:0] MD [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    localparam logic [1:0] PT [5] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h2};
    localparam logic [4:0] PR [5] = '{5'h07, 5'h00, 5'h00, 5'h05, 5'h00};
    localparam logic [4:0] IX [5] = '{5'h17, 5'h08, 5'h01, 5'h05, 5'h10};
    irt_top i_irt_top (.*);
    always #25 sys_clk = ~sys_clk;
    task finish_test;
        if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // address and data offered together, each dropped once taken
    task wr(input logic [15:0] a, input logic [31:0] dv, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge sys_clk);
            if (s_axi_bvalid) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (n == 100) chk(32'h0, 32'h1);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task rd(input logic [15:0] a, output logic [31:0] dv, output logic [1:0] rr);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge sys_clk);
            if (s_axi_rvalid) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (n == 100) chk(32'h0, 32'h1);
        dv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    task rchk(input logic [15:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk(d, exp);
    endtask
    // launch a command, then poll pending until it clears
    task cmd(input logic [7:0] c);
        int n;
        wr(A_CMD, {24'h0, c}, irt_pkg::RESP_OKAY);
        rd(A_STS, d, r);
        if (c[7]) chk({31'h0, d[0]}, 32'h1);
        for (n = 0; n < 20 && d[0] !== 1'b0; n++) rd(A_STS, d, r);
        chk({31'h0, d[0]}, 32'h0);
    endtask
    task tget(input logic [7:0] c, input logic [31:0] exp);
        cmd(c);
        rchk(A_RD, exp);
    endtask
    // reset, then the access sequences
    initial begin
        {sys_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, meter_port, meter_prio} = '0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
        {error_cnt, tests_run} = '0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        rchk(A_CFG, 32'h0);
        rchk(A_STS, 32'h0);
        tget(8'hA0, 32'h0014);
        tget(8'hB7, 32'h0014);
        tget(8'hC0, 32'h0600);
        tget(8'hE0, 32'h0600);
        for (i = 0; i < 24; i++) begin
            wr(A_WR, 32'hFFFF_0100 + i, irt_pkg::RESP_OKAY);
            cmd({3'b001, i[4:0]});
        end
        wr(A_WR, 32'h0000_A5A5, irt_pkg::RESP_OKAY);
        cmd(8'h40);
        wr(A_WR, 32'h0000_5A5A, irt_pkg::RESP_OKAY);
        cmd(8'h60);
        for (i = 0; i < 24; i++) tget({3'b101, i[4:0]}, 32'h0100 + i);
        tget(8'hC0, 32'h0000_A5A5);
        tget(8'hE0, 32'h0000_5A5A);
        tget(8'h80, 32'h0);
        rchk(A_CMD, 32'h0000_0080);
        wr(A_BAD, 32'h1, irt_pkg::RESP_SLVERR);
        rd(A_BAD, d, r);
        chk({d[31:2], r}, {30'h0, irt_pkg::RESP_SLVERR});
        for (i = 0; i < 5; i++) begin
            wr(A_CFG, {29'h0, MD[i], 1'b1}, irt_pkg::RESP_OKAY);
            meter_port <= PT[i];
            meter_prio <= PR[i];
            repeat (4) @(posedge sys_clk);
            e = (21'h0101 + IX[i]) * 21'h14;
            chk({29'h0, meter_mode, meter_enable}, {29'h0, MD[i], 1'b1});
            chk({16'h0, meter_rate}, 32'h0100 + IX[i]);
            chk({11'h0, meter_ns_per_byte}, {11'h0, e});
        end
        finish_test;
    end
    // hang guard, well past the expected run
    initial begin
        #1000000;
        error_cnt++;
        finish_test;
    end
endmodule
